// File: rtl/ebac_area_cfg.sv
// area configuration register bank with apb slave and area decode
//
// Notes on behaviour
// - area 5 burst: sram, 4/8/16/32 beats
// - area 6 burst uses same coding
// - mux area ignores its burst field
// - type 000/010/011 sram and sdram mixes
// - type 100/101 dram; others reserved, unsettable
// - sram-typed areas 1-6 follow mux select bit; area 0 stays sram
// - dual dram: mode pin five is strobe
// - card bit: areas 5 and 6 override mux, card enables
// - width register loads 3ffc at power-on
// - width bits 15:14 read-only strap capture
// - area n (1..6) width at bits 2n+1:2n; area 0 width is the strap at 15:14
// - bit 0 frees data pins as port
// - width bit 1 reads zero
// - bit 17 selects mux interface
`timescale 1ns/10ps
`default_nettype none
module ebac_area_cfg
    import ebac_pkg::*;
(
    // clock and resets
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic por_pin,
    // apb slave
    input wire ebac_apb_req_s apb_req,
    output ebac_apb_rsp_s apb_rsp,
    // mode strap pins
    input wire logic mode_pin_three,
    input wire logic mode_pin_four,
    // access sequencer handshake
    input wire logic access_start,
    input wire logic [2:0] access_area,
    output ebac_area_s access_cfg,
    // pin function overrides
    output ebac_pins_s pin_func
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] ctrl1;
        logic [15:0] width;
        ebac_area_s cfg;
        logic [31:0] rdata;
        logic rejected;
        logic strap_pend;
    } ebac_state_s;

    ebac_state_s st;
    ebac_state_s next_st;
    ebac_area_s area_dec [0:6];
    logic [5:0] beats5;
    logic [5:0] beats6;
    logic burst5;
    logic burst6;
    logic card;
    logic mux;
    logic [2:0] mtype;
    logic wr_done;
    logic [31:0] wval;
    logic width_wr;
    logic ctrl_wr;

    assign card = st.ctrl1[EBAC_C1_CARD];
    assign mux = st.ctrl1[EBAC_C1_MUX];
    assign mtype = st.ctrl1[EBAC_C1_TYPE_LO +: 3];
    assign wr_done = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign wval = apb_req.pwdata;
    assign width_wr = wr_done && (apb_req.paddr == EBAC_OFF_WIDTH);
    assign ctrl_wr = wr_done && (apb_req.paddr == EBAC_OFF_CTRL1);

    // ------------------------------------------------------------
    // burst decode
    // ------------------------------------------------------------
    // area 5 burst
    ebac_burst_dec u_bst5 (
        .code(st.ctrl1[EBAC_C1_A5_LO +: 3]),
        .mux_area(mux & ~card),
        .burst_on(burst5),
        .beats(beats5)
    );
    ebac_burst_dec u_bst6 (
        .code(st.ctrl1[EBAC_C1_A6_LO +: 3]),
        .mux_area(mux & ~card),
        .burst_on(burst6),
        .beats(beats6)
    );

    // ------------------------------------------------------------
    // per-area decode
    // ------------------------------------------------------------
    always_comb begin
        for (int n = 0; n <= 6; n++) begin
            area_dec[n].width = (n == 0) ? st.width[EBAC_W_STRAP_LO +: 2]
                                         : st.width[2*n +: 2];
            area_dec[n].beats = '0;
            area_dec[n].kind = mux ? EBAC_IF_MUX : EBAC_IF_SRAM;
        end
        // area 0 mux choice is outside this bank
        area_dec[0].kind = EBAC_IF_SRAM;
        unique case (mtype)
            EBAC_MT_A3SD: area_dec[3].kind = EBAC_IF_SDRAM;
            EBAC_MT_SDSD: begin
                area_dec[2].kind = EBAC_IF_SDRAM;
                area_dec[3].kind = EBAC_IF_SDRAM;
            end
            EBAC_MT_A3DR: area_dec[3].kind = EBAC_IF_DRAM;
            EBAC_MT_DRDR: begin
                area_dec[2].kind = EBAC_IF_DRAM;
                area_dec[3].kind = EBAC_IF_DRAM;
            end
            default: ;
        endcase
        // card overrides mux for areas 5 and 6
        if (card) begin
            area_dec[5].kind = EBAC_IF_CARD;
            area_dec[6].kind = EBAC_IF_CARD;
        end else begin
            if (burst5) begin
                area_dec[5].kind = EBAC_IF_BURST;
                area_dec[5].beats = beats5;
            end
            if (burst6) begin
                area_dec[6].kind = EBAC_IF_BURST;
                area_dec[6].beats = beats6;
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rejected = 1'b0;
        // settings latched only when an access starts
        if (access_start) begin
            next_st.cfg = area_dec[(access_area > 3'h6) ? 3'h0 : access_area];
        end
        if (ctrl_wr) begin
            next_st.ctrl1 = wval & EBAC_C1_MASK;
            // reserved type codes cannot be set
            if (!(wval[EBAC_C1_TYPE_LO +: 3] inside {EBAC_MT_SRAM,
                    EBAC_MT_A3SD, EBAC_MT_SDSD, EBAC_MT_A3DR,
                    EBAC_MT_DRDR})) begin
                next_st.ctrl1[EBAC_C1_TYPE_LO +: 3] = mtype;
                next_st.rejected = 1'b1;
            end
        end
        if (width_wr) begin
            // strap bits kept, bit 1 stays zero
            next_st.width = (wval[15:0] & EBAC_W_MASK)
                          | (st.width & ~EBAC_W_MASK);
            next_st.width[EBAC_W_RSVD] = 1'b0;
        end
        if (st.strap_pend) begin
            next_st.width[EBAC_W_STRAP_LO +: 2] = {mode_pin_four,
                                                   mode_pin_three};
            next_st.strap_pend = 1'b0;
        end
        unique case (apb_req.paddr)
            EBAC_OFF_CTRL1: next_st.rdata = st.ctrl1;
            EBAC_OFF_WIDTH: next_st.rdata = {16'h0000, st.width};
            EBAC_OFF_STAT: next_st.rdata = {29'h0000_0000, st.cfg.kind};
            default: next_st.rdata = '0;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // power-on loads everything; srst alone keeps the bank
    // srst wins over a same-cycle write, so that write is lost
    always_ff @(posedge sys_clk) begin
        if (por_pin) begin
            st.ctrl1 <= '0;
            st.width <= EBAC_WIDTH_RESET;
            st.cfg <= '0;
            st.rdata <= '0;
            st.rejected <= 1'b0;
            st.strap_pend <= 1'b1;
        end else if (srst) begin
            st.rdata <= '0;
            st.rejected <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // zero-wait slave; read data is registered in the setup cycle,
    // so it already stands when the access phase completes
    always_comb begin
        apb_rsp.pready = 1'b1;
        apb_rsp.pslverr = apb_req.psel & apb_req.penable
                        & !(apb_req.paddr inside {EBAC_OFF_CTRL1,
                            EBAC_OFF_WIDTH, EBAC_OFF_STAT});
        apb_rsp.prdata = st.rdata;
    end
    assign access_cfg = st.cfg;
    // dual dram turns mode pin five into strobe
    assign pin_func.second_row_strobe_en = (mtype == EBAC_MT_DRDR);
    // card enables on mode pins three and four
    assign pin_func.card_enable_a_en = card;
    assign pin_func.card_enable_b_en = card;
    // port enable frees upper data pins
    assign pin_func.data_pin_port_enable = st.width[EBAC_W_PORT];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // software write of the width register
    sequence s_width_write;
        width_wr;
    endsequence
    // software write of the first control register
    sequence s_ctrl_write;
        ctrl_wr;
    endsequence
    // strap capture cycle right after power-on release
    sequence s_strap_cycle;
        st.strap_pend && !por_pin && !srst;
    endsequence

    a_width_por_val: assert property (@(posedge sys_clk)
        $past(por_pin) && !por_pin |->
            st.width[13:0] == EBAC_WIDTH_RESET[13:0])
        else $error("width register not at power-on value");
    a_strap_keep: assert property (@(posedge sys_clk)
        disable iff (por_pin) (s_width_write and !st.strap_pend)
            |=> $stable(st.width[15:14]))
        else $error("strap bits changed by a write");
    a_strap_load: assert property (@(posedge sys_clk)
        disable iff (por_pin) s_strap_cycle |=> st.width[15:14]
            == $past({mode_pin_four, mode_pin_three}))
        else $error("strap pins not captured");
    a_rsvd_zero: assert property (@(posedge sys_clk)
        disable iff (por_pin) !$past(por_pin) |-> st.width[1] == 1'b0)
        else $error("width bit 1 not zero");
    a_srst_keeps: assert property (@(posedge sys_clk)
        disable iff (por_pin) srst
            |=> $stable(st.width) && $stable(st.ctrl1))
        else $error("bank lost contents on soft reset");
    a_ctrl_write: assert property (@(posedge sys_clk)
        disable iff (por_pin || srst) s_ctrl_write |=> st.rejected
            == ($past(apb_req.pwdata[4:2]) inside {3'h1, 3'h6, 3'h7}))
        else $error("reserved type write not refused");
    a_type_reject: assert property (@(posedge sys_clk)
        disable iff (por_pin || srst) st.rejected |-> $stable(mtype))
        else $error("refused type write changed the field");
    a_type_legal: assert property (@(posedge sys_clk)
        disable iff (por_pin) !(mtype inside {3'h1, 3'h6, 3'h7}))
        else $error("reserved memory type set");
    a_card_pins: assert property (@(posedge sys_clk)
        card |-> pin_func.card_enable_a_en && pin_func.card_enable_b_en
            && area_dec[5].kind == EBAC_IF_CARD)
        else $error("card mode not applied");
    a_mux_burst: assert property (@(posedge sys_clk)
        mux && !card |-> area_dec[5].kind == EBAC_IF_MUX
            && area_dec[6].beats == 6'h00)
        else $error("burst field used on mux area");
    a_burst_32: assert property (@(posedge sys_clk)
        !mux && !card && st.ctrl1[10:8] == 3'h4
            |-> area_dec[5].beats == 6'h20)
        else $error("32-beat burst decoded wrong");
    a_cfg_hold: assert property (@(posedge sys_clk)
        disable iff (por_pin || srst) !access_start |=> $stable(access_cfg))
        else $error("access settings changed mid access");
    a_row_strobe: assert property (@(posedge sys_clk)
        mtype == 3'h5 |-> pin_func.second_row_strobe_en
            && area_dec[2].kind == EBAC_IF_DRAM)
        else $error("dual dram pin not assigned");
    a_port_en: assert property (@(posedge sys_clk)
        disable iff (por_pin || srst) s_width_write
            |=> pin_func.data_pin_port_enable
                == $past(apb_req.pwdata[EBAC_W_PORT]))
        else $error("port enable mismatch");
    a_mux_sram: assert property (@(posedge sys_clk)
        mux && mtype == 3'h0 |-> area_dec[2].kind == EBAC_IF_MUX)
        else $error("mux select ignored");
    a_burst_rsvd: assert property (@(posedge sys_clk)
        !mux && !card && st.ctrl1[7:5] inside {3'h5, 3'h6, 3'h7}
            |-> area_dec[6].kind == EBAC_IF_SRAM)
        else $error("reserved burst code not plain access");
    a_cfg_latch: assert property (@(posedge sys_clk)
        disable iff (por_pin || srst) access_start && access_area == 3'h5
            |=> access_cfg == $past(area_dec[5]))
        else $error("access settings not latched");
endmodule : ebac_area_cfg
`default_nettype wire

// File: pkg/ebac_pkg.sv
// package: register map, field layout and decode types of the area config
package ebac_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses on the apb bus)
    // ------------------------------------------------------------
    localparam logic [7:0] EBAC_OFF_CTRL1 = 8'h00;
    localparam logic [7:0] EBAC_OFF_WIDTH = 8'h04;
    localparam logic [7:0] EBAC_OFF_STAT = 8'h08;

    // ------------------------------------------------------------
    // first control register fields
    // ------------------------------------------------------------
    localparam int EBAC_C1_MUX = 17;
    localparam int EBAC_C1_A5_LO = 8;
    localparam int EBAC_C1_A6_LO = 5;
    localparam int EBAC_C1_TYPE_LO = 2;
    localparam int EBAC_C1_CARD = 0;
    // writable bits of the first control register
    localparam logic [31:0] EBAC_C1_MASK = 32'h0002_07fd;

    // ------------------------------------------------------------
    // width register fields
    // ------------------------------------------------------------
    localparam logic [15:0] EBAC_WIDTH_RESET = 16'h3ffc;
    localparam int EBAC_W_STRAP_LO = 14;
    localparam int EBAC_W_PORT = 0;
    localparam int EBAC_W_RSVD = 1;
    // software-writable bits: area 1..6 widths and the port enable
    localparam logic [15:0] EBAC_W_MASK = 16'h3ffd;
    localparam logic [1:0] EBAC_WID_64 = 2'h0;

    // ------------------------------------------------------------
    // burst and memory type codes
    // ------------------------------------------------------------
    localparam logic [2:0] EBAC_BST_SRAM = 3'h0;
    localparam logic [2:0] EBAC_BST_4 = 3'h1;
    localparam logic [2:0] EBAC_BST_8 = 3'h2;
    localparam logic [2:0] EBAC_BST_16 = 3'h3;
    localparam logic [2:0] EBAC_BST_32 = 3'h4;
    localparam logic [5:0] EBAC_BEATS_4 = 6'h04;
    localparam logic [5:0] EBAC_BEATS_8 = 6'h08;
    localparam logic [5:0] EBAC_BEATS_16 = 6'h10;
    localparam logic [5:0] EBAC_BEATS_32 = 6'h20;

    localparam logic [2:0] EBAC_MT_SRAM = 3'h0;
    localparam logic [2:0] EBAC_MT_A3SD = 3'h2;
    localparam logic [2:0] EBAC_MT_SDSD = 3'h3;
    localparam logic [2:0] EBAC_MT_A3DR = 3'h4;
    localparam logic [2:0] EBAC_MT_DRDR = 3'h5;

    // interface kind of one area, as seen by the access sequencers
    typedef enum logic [2:0] {
        EBAC_IF_SRAM = 3'h0,
        EBAC_IF_BURST = 3'h1,
        EBAC_IF_MUX = 3'h2,
        EBAC_IF_SDRAM = 3'h3,
        EBAC_IF_DRAM = 3'h4,
        EBAC_IF_CARD = 3'h5
    } ebac_if_e;

    // one area's decoded settings
    typedef struct packed {
        ebac_if_e kind;
        logic [5:0] beats;
        logic [1:0] width;
    } ebac_area_s;

    // apb request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ebac_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ebac_apb_rsp_s;

    // pin function overrides
    typedef struct packed {
        logic second_row_strobe_en;
        logic card_enable_a_en;
        logic card_enable_b_en;
        logic data_pin_port_enable;
    } ebac_pins_s;

endpackage : ebac_pkg

// File: rtl/ebac_burst_dec.sv
// burst field decode for one area
`timescale 1ns/10ps
`default_nettype none
module ebac_burst_dec
    import ebac_pkg::*;
(
    // field and qualifiers
    input wire logic [2:0] code,
    input wire logic mux_area,
    // decoded result
    output logic burst_on,
    output logic [5:0] beats
);
    always_comb begin
        burst_on = 1'b1;
        beats = EBAC_BEATS_4;
        unique case (code)
            EBAC_BST_4: beats = EBAC_BEATS_4;
            EBAC_BST_8: beats = EBAC_BEATS_8;
            EBAC_BST_16: beats = EBAC_BEATS_16;
            EBAC_BST_32: beats = EBAC_BEATS_32;
            default: begin
                burst_on = 1'b0;
                beats = '0;
            end
        endcase
        if (mux_area) begin
            burst_on = 1'b0;
            beats = '0;
        end
    end
endmodule : ebac_burst_dec
`default_nettype wire

// File: dv/ebac_seq_model.sv
// access sequencer model: starts external accesses one area at a time
`timescale 1ns/10ps
`default_nettype none
module ebac_seq_model
    import ebac_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // access request
    output var logic access_start,
    output var logic [2:0] access_area
);
    initial begin
        access_start = 1'b0;
        access_area = 3'h7;
    end

    // one pulse per access, settings judged after it
    task automatic start(input logic [2:0] area);
        @(posedge sys_clk);
        access_start <= 1'b1;
        access_area <= area;
        @(posedge sys_clk);
        access_start <= 1'b0;
        // idle area is inverted so a stale value never equals the area just started
        access_area <= ~area;
        #1;
    endtask : start
endmodule : ebac_seq_model
`default_nettype wire

// File: dv/tb.sv
// testbench top: register access and area decode scenarios
`timescale 1ns/10ps
`default_nettype none
module tb
    import ebac_pkg::*;
;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic sys_clk;
    logic srst;
    logic por_pin;
    logic mode_pin_three;
    logic mode_pin_four;
    ebac_apb_req_s apb_req;
    ebac_apb_rsp_s apb_rsp;
    logic access_start;
    logic [2:0] access_area;
    ebac_area_s access_cfg;
    ebac_pins_s pin_func;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;

    ebac_area_cfg ebac_area_cfg_inst (.sys_clk(sys_clk), .srst(srst),
        .por_pin(por_pin), .apb_req(apb_req), .apb_rsp(apb_rsp),
        .mode_pin_three(mode_pin_three), .mode_pin_four(mode_pin_four),
        .access_start(access_start), .access_area(access_area),
        .access_cfg(access_cfg), .pin_func(pin_func));
    ebac_seq_model ebac_seq_model_inst (.sys_clk(sys_clk),
        .access_start(access_start), .access_area(access_area));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wdata);
        @(posedge sys_clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= addr;
        apb_req.pwdata <= wdata;
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        #1;
    endtask : apb

    task automatic acc(input logic [2:0] area, input logic [2:0] kind);
        ebac_seq_model_inst.start(area);
        check("area kind", access_cfg.kind, kind);
    endtask : acc

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        apb(1'b0, EBAC_OFF_CTRL1, 32'h0);
        check("ctrl1 reset", rd, 32'h0);
        apb(1'b0, EBAC_OFF_WIDTH, 32'h0);
        check("width reset", rd, 32'h0000_bffc);
        acc(3'h0, EBAC_IF_SRAM);
        check("area0 width", access_cfg.width, 32'h2);
    endtask : t_reset

    // width set up before areas other than 0 are used
    task automatic t_width();
        apb(1'b1, EBAC_OFF_WIDTH, 32'h0000_ffff);
        apb(1'b0, EBAC_OFF_WIDTH, 32'h0);
        check("width ro bits", rd, 32'h0000_bffd);
        check("port enable", pin_func.data_pin_port_enable, 32'h1);
        apb(1'b1, EBAC_OFF_WIDTH, 32'h0000_39e4);
        check("port off", pin_func.data_pin_port_enable, 32'h0);
        for (int n = 1; n <= 6; n++) begin
            acc(n[2:0], EBAC_IF_SRAM);
            check("area width", access_cfg.width, ((n - 1) % 3) + 1);
        end
        // manual reset must leave the settings alone
        @(posedge sys_clk) srst <= 1'b1;
        @(posedge sys_clk) srst <= 1'b0;
        apb(1'b0, EBAC_OFF_WIDTH, 32'h0);
        check("width after srst", rd, 32'h0000_b9e4);
        apb(1'b1, EBAC_OFF_WIDTH, 32'h0);
        acc(3'h1, EBAC_IF_SRAM);
        check("width 64", access_cfg.width, 32'h0);
    endtask : t_width

    task automatic t_type();
        logic [2:0] cur;
        logic [2:0] k2;
        logic [2:0] k3;
        apb(1'b1, EBAC_OFF_WIDTH, 32'h0000_3ffc);
        cur = 3'h0;
        for (int t = 0; t < 8; t++) begin
            apb(1'b1, EBAC_OFF_CTRL1, t << 2);
            if (t inside {0, 2, 3, 4, 5}) cur = t[2:0];
            apb(1'b0, EBAC_OFF_CTRL1, 32'h0);
            check("type field", rd, {27'h0, cur, 2'h0});
            k2 = (cur == 3'h3) ? EBAC_IF_SDRAM :
                 (cur == 3'h5) ? EBAC_IF_DRAM : EBAC_IF_SRAM;
            k3 = (cur == 3'h0) ? EBAC_IF_SRAM :
                 (cur inside {2, 3}) ? EBAC_IF_SDRAM : EBAC_IF_DRAM;
            acc(3'h2, k2);
            acc(3'h3, k3);
            check("row strobe", pin_func.second_row_strobe_en, cur == 5);
        end
        apb(1'b1, EBAC_OFF_CTRL1, 32'h0002_0008);
        acc(3'h2, EBAC_IF_MUX);
        acc(3'h3, EBAC_IF_SDRAM);
        acc(3'h1, EBAC_IF_MUX);
    endtask : t_type

    task automatic t_burst();
        logic [5:0] bt;
        // 8-bit areas keep every burst length legal
        apb(1'b1, EBAC_OFF_WIDTH, 32'h0000_1554);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, EBAC_OFF_CTRL1, (c << 8) | (c << 5));
            bt = (c >= 1 && c <= 4) ? 6'h02 << c : 6'h00;
            acc(3'h5, bt != 0 ? EBAC_IF_BURST : EBAC_IF_SRAM);
            if (bt != 0) check("a5 beats", access_cfg.beats, bt);
            acc(3'h6, bt != 0 ? EBAC_IF_BURST : EBAC_IF_SRAM);
            if (bt != 0) check("a6 beats", access_cfg.beats, bt);
        end
        apb(1'b1, EBAC_OFF_CTRL1, 32'h0000_0100);
        acc(3'h5, EBAC_IF_BURST);
        apb(1'b1, EBAC_OFF_CTRL1, 32'h0000_0200);
        check("held beats", access_cfg.beats, EBAC_BEATS_4);
        acc(3'h5, EBAC_IF_BURST);
        check("new beats", access_cfg.beats, EBAC_BEATS_8);
        apb(1'b1, EBAC_OFF_CTRL1, 32'h0002_0120);
        acc(3'h5, EBAC_IF_MUX);
        acc(3'h6, EBAC_IF_MUX);
        // burst fields cleared by the same write that chooses the card interface
        apb(1'b1, EBAC_OFF_CTRL1, 32'h0002_0001);
        acc(3'h5, EBAC_IF_CARD);
        acc(3'h6, EBAC_IF_CARD);
        check("card a", pin_func.card_enable_a_en, 32'h1);
        check("card b", pin_func.card_enable_b_en, 32'h1);
        acc(3'h1, EBAC_IF_MUX);
        apb(1'b0, EBAC_OFF_STAT, 32'h0);
        check("status kind", rd[2:0], EBAC_IF_MUX);
    endtask : t_burst

    // unmapped place, dead bits and a second power-on
    task automatic t_misc();
        apb(1'b1, 8'h0c, 32'h0000_0001);
        check("unmapped err", err, 32'h1);
        apb(1'b1, EBAC_OFF_CTRL1, 32'h0000_f802);
        apb(1'b0, EBAC_OFF_CTRL1, 32'h0);
        check("ctrl1 dead bits", rd, 32'h0);
        @(posedge sys_clk);
        mode_pin_four <= 1'b0;
        mode_pin_three <= 1'b1;
        por_pin <= 1'b1;
        @(posedge sys_clk) por_pin <= 1'b0;
        apb(1'b0, EBAC_OFF_WIDTH, 32'h0);
        check("width por", rd, 32'h0000_7ffc);
    endtask : t_misc

    // ------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // the whole run needs a few hundred cycles; this leaves ample room
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    initial begin
        srst = 1'b1;
        por_pin = 1'b1;
        mode_pin_four = 1'b1;
        mode_pin_three = 1'b0;
        apb_req = '0;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        por_pin <= 1'b0;
        t_reset();
        t_width();
        t_type();
        t_burst();
        t_misc();
        conclude();
    end
endmodule : tb
`default_nettype wire
